// ==== dv/tmc0_timer_bench.sv ====
`timescale 1ns/1ps
module tmc0_timer_bench;
  import tmc0_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tmc0b_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_pin = 1'b0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic ack_ovf = 1'b0;
  logic [7:0] rd_data, count_value, snap;
  logic out_a, out_b, en_a, en_b, flag_a, flag_b, ovf, tce;
  int err_count = 0;
  int n_checks = 0;
  int k;
  tmc0b_row_t rows [9] = '{'{8'h2A, 8'hFF, 8'hF3}, '{8'h2A, 8'h00, 8'h00},
    '{8'h33, 8'hCF, 8'h0F}, '{8'h33, 8'h00, 8'h00}, '{8'h29, 8'h5A, 8'h5A},
    '{8'h28, 8'hA5, 8'hA5}, '{8'h2C, 8'h7E, 8'h00}, '{8'h50, 8'hFF, 8'h00},
    '{8'h32, 8'h3C, 8'h3C}};
  int cs_n [5] = '{16, 64, 128, 512, 2048};
  logic [7:0] cs_e [5] = '{8'h10, 8'h08, 8'h02, 8'h02, 8'h02};
  logic [1:0] f_c [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic f_e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  always #2 clk = ~clk;

  tmc0_timer u_tmc0_timer (.clk(clk), .srst(srst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .external_count_pin(ext_pin), .ack_match_a(ack_a), .ack_match_b(ack_b),
    .ack_overflow(ack_ovf), .wave_out_a(out_a), .wave_out_b(out_b),
    .wave_en_a(en_a), .wave_en_b(en_b), .match_flag_a(flag_a),
    .match_flag_b(flag_b), .overflow_flag(ovf), .count_value(count_value),
    .timer_count_enable(tce));

  task finish_test;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // each access opens on a fresh edge, so strobes never collide
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, e);
  endtask : rd

  task cnt(input int n, input logic [7:0] e);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (tce === 1'b1) k++;
    end
    chk(k[7:0], e);
  endtask : cnt

  // bounded wait, a hang shows up as a mismatch here
  task wait_count(input logic [7:0] v);
    k = 0;
    #1;
    while (count_value !== v && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(count_value, v);
  endtask : wait_count

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(TMC0_ADDR_CTRL_A, 8'h00);
    rd(TMC0_ADDR_SYNC, 8'h00);
    rd(TMC0_ADDR_CTRL_B, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    for (int i = 0; i < 5; i++) begin
      wr(TMC0_ADDR_CTRL_B, 8'(i + 1));
      cnt(cs_n[i], cs_e[i]);
    end
    wr(TMC0_ADDR_CTRL_B, 8'h00);
    cnt(16, 8'h00);
    wr(TMC0_ADDR_FLAGS, 8'h1A);
    rd(TMC0_ADDR_FLAGS, 8'h00);
    wr(TMC0_ADDR_COUNT, 8'hFD);
    wr(TMC0_ADDR_CTRL_B, 8'h01);
    wait_count(8'h00);
    chk({7'h00, ovf}, 8'h01);
    @(posedge clk);
    ack_ovf <= 1'b1;
    @(posedge clk);
    ack_ovf <= 1'b0;
    #1;
    chk({7'h00, ovf}, 8'h00);
    wait_count(8'h5B);
    chk({7'h00, flag_a}, 8'h01);
    @(posedge clk);
    ack_a <= 1'b1;
    ack_b <= 1'b1;
    @(posedge clk);
    ack_a <= 1'b0;
    ack_b <= 1'b0;
    #1;
    chk({6'h00, flag_a, flag_b}, 8'h00);
    wr(TMC0_ADDR_SYNC, 8'h81);
    cnt(8, 8'h00);
    rd(TMC0_ADDR_SYNC, 8'h81);
    wr(TMC0_ADDR_SYNC, 8'h00);
    rd(TMC0_ADDR_SYNC, 8'h00);
    cnt(8, 8'h08);
    wr(TMC0_ADDR_SYNC, 8'h01);
    @(posedge clk);
    rd(TMC0_ADDR_SYNC, 8'h00);
    wr(TMC0_ADDR_CTRL_B, 8'h00);
    wr(TMC0_ADDR_CTRL_A, 8'h00);
    wr(TMC0_ADDR_FLAGS, 8'h1A);
    for (int i = 0; i < 4; i++) begin
      wr(TMC0_ADDR_CTRL_A, {f_c[i], f_c[i], 4'h0});
      snap = count_value;
      wr(TMC0_ADDR_CTRL_B, 8'hC0);
      @(posedge clk);
      #1;
      chk({6'h00, out_a, out_b}, {6'h00, f_e[i], f_e[i]});
      chk({6'h00, flag_a, flag_b}, 8'h00);
      chk(count_value, snap);
      chk({6'h00, en_a, en_b}, 8'h03);
    end
    // new compare sits in the buffer until the wrap, 0x60 tells old from new
    wr(TMC0_ADDR_CTRL_A, 8'h83);
    wr(TMC0_ADDR_CMP_A, 8'h80);
    wr(TMC0_ADDR_CTRL_B, 8'h01);
    repeat (300) @(posedge clk);
    wait_count(8'h60);
    chk({7'h00, out_a}, 8'h01);
    wait_count(8'hC0);
    chk({7'h00, out_a}, 8'h00);
    // two rises and one fall on the pin, so only rising edges may count
    wr(TMC0_ADDR_CTRL_B, 8'h07);
    #1;
    snap = count_value;
    repeat (3) begin
      @(posedge clk);
      ext_pin <= ~ext_pin;
      repeat (5) @(posedge clk);
    end
    #1;
    chk(count_value, snap + 8'h02);
    // phase correct from zero: set on the way up, clear on the way down
    wr(TMC0_ADDR_CTRL_A, 8'hC1);
    wr(TMC0_ADDR_COUNT, 8'h00);
    wr(TMC0_ADDR_FLAGS, 8'h02);
    wr(TMC0_ADDR_CTRL_B, 8'h01);
    wait_count(8'hFF);
    chk({6'h00, out_a, ovf}, 8'h02);
    wait_count(8'h40);
    chk({7'h00, out_a}, 8'h00);
    wait_count(8'h00);
    wait_count(8'h02);
    chk({7'h00, ovf}, 8'h01);
    finish_test();
  end
endmodule : tmc0_timer_bench

// ==== dv/tmc0_timer_sva.sv ====
`timescale 1ns/1ps
module tmc0_timer_sva
  import tmc0_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic wave_en_a,
  input wire logic overflow_flag,
  input wire logic [7:0] count_value,
  input wire logic timer_count_enable
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_rd_idle;
    !rd_en |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_ctrl_a_rsvd;
    rd_en && addr == TMC0_ADDR_CTRL_A |=> rd_data[3:2] == 2'h0;
  endproperty
  a_ctrl_a_rsvd: assert property (p_ctrl_a_rsvd)
    else $error("bits 3:2 set");
  property p_force_rd;
    rd_en && addr == TMC0_ADDR_CTRL_B |=> rd_data[7:6] == 2'h0;
  endproperty
  a_force_rd: assert property (p_force_rd)
    else $error("force bits read");
  property p_wave_en;
    wr_en && addr == TMC0_ADDR_CTRL_A |=>
      wave_en_a == ($past(wr_data[7:6]) != 2'h0);
  endproperty
  a_wave_en: assert property (p_wave_en)
    else $error("pin override a");
  property p_en_hold;
    !(wr_en && addr == TMC0_ADDR_CTRL_A) |=> $stable(wave_en_a);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("override moved");
  // reset clears the counter, so the edge after reset is exempt
  property p_count_cause;
    count_value != $past(count_value) && !$past(srst)
      && !$past(wr_en && addr == TMC0_ADDR_COUNT) |-> timer_count_enable;
  endproperty
  a_count_cause: assert property (p_count_cause)
    else $error("stray count");
  property p_hold_halt;
    wr_en && addr == TMC0_ADDR_SYNC && wr_data[7] && wr_data[0]
      |=> ##1 !timer_count_enable [*4];
  endproperty
  a_hold_halt: assert property (p_hold_halt)
    else $error("ran in hold");
  // an overflow in the clearing cycle wins; it leaves the counter at 0 or 1
  property p_ovf_w1c;
    wr_en && addr == TMC0_ADDR_FLAGS && wr_data[1] |=>
      !overflow_flag || (timer_count_enable && count_value <= 8'h01);
  endproperty
  a_ovf_w1c: assert property (p_ovf_w1c)
    else $error("overflow kept");
endmodule : tmc0_timer_sva

bind tmc0_timer tmc0_timer_sva u_tmc0_timer_sva (.clk(clk), .srst(srst),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .wave_en_a(wave_en_a), .overflow_flag(overflow_flag),
  .count_value(count_value), .timer_count_enable(timer_count_enable));

// ==== src/tmc0_pkg.sv ====
package tmc0_pkg;

  localparam int unsigned TMC0_AW = 8;

  // register map
  localparam logic [7:0] TMC0_ADDR_CMP_B = 8'h28;
  localparam logic [7:0] TMC0_ADDR_CMP_A = 8'h29;
  localparam logic [7:0] TMC0_ADDR_CTRL_A = 8'h2A;
  localparam logic [7:0] TMC0_ADDR_SYNC = 8'h2C;
  localparam logic [7:0] TMC0_ADDR_COUNT = 8'h32;
  localparam logic [7:0] TMC0_ADDR_CTRL_B = 8'h33;
  localparam logic [7:0] TMC0_ADDR_FLAGS = 8'h38;

  // field positions
  localparam int unsigned TMC0_SYNC_HOLD_BIT = 7;
  localparam int unsigned TMC0_PRESC_RST_BIT = 0;
  localparam int unsigned TMC0_FORCE_A_BIT = 7;
  localparam int unsigned TMC0_MODE_HI_BIT = 3;
  localparam int unsigned TMC0_FLAG_A_BIT = 4;
  localparam int unsigned TMC0_FLAG_B_BIT = 3;
  localparam int unsigned TMC0_FLAG_OVF_BIT = 1;

  localparam logic [7:0] TMC0_REG_RESET = 8'h00;
  localparam logic [7:0] TMC0_MAX = 8'hFF;
  localparam logic [7:0] TMC0_BOTTOM = 8'h00;

  // waveform modes
  localparam logic [2:0] TMC0_M_NORMAL = 3'h0;
  localparam logic [2:0] TMC0_M_PC_FF = 3'h1;
  localparam logic [2:0] TMC0_M_CTC = 3'h2;
  localparam logic [2:0] TMC0_M_FAST_FF = 3'h3;
  localparam logic [2:0] TMC0_M_PC_A = 3'h5;
  localparam logic [2:0] TMC0_M_FAST_A = 3'h7;

  // clock select codes
  localparam logic [2:0] TMC0_CS_STOP = 3'h0;
  localparam logic [2:0] TMC0_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMC0_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMC0_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMC0_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMC0_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMC0_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMC0_CS_EXT_RISE = 3'h7;

  // prescaler tap masks, a tap fires when all masked bits are one
  localparam logic [9:0] TMC0_TAP8 = 10'h007;
  localparam logic [9:0] TMC0_TAP64 = 10'h03F;
  localparam logic [9:0] TMC0_TAP256 = 10'h0FF;
  localparam logic [9:0] TMC0_TAP1024 = 10'h3FF;

  typedef enum logic [1:0] {
    TMC0_UP = 2'b01,
    TMC0_DOWN = 2'b10
  } tmc0_dir_t;

  typedef struct packed {
    logic sync_hold_mode;
    logic prescaler_reset_bit;
    logic [1:0][1:0] out_action;
    logic [2:0] wave_mode;
    logic [2:0] clock_select_field;
    logic [7:0] count_value;
    logic [1:0][7:0] cmp_active;
    logic [1:0][7:0] cmp_buffer;
    tmc0_dir_t dir;
    logic block_match;
    logic [1:0] match_flag;
    logic overflow_flag;
    logic [1:0] wave_out;
    logic [1:0] wave_en;
    logic [9:0] presc;
    logic [2:0] pin_sync;
    logic pin_level;
    logic tick_q;
    logic [7:0] rd_data;
  } tmc0_state_t;

  localparam tmc0_state_t TMC0_STATE_RESET = '{dir: TMC0_UP, default: '0};

endpackage : tmc0_pkg

// ==== src/tmc0_timer.sv ====
`timescale 1ns/1ps
// Function
// - counter moves only on cycles where the prescaled count enable is high, or after a counter register write
// - sync hold mode keeps prescaler reset set; clearing it releases counting
// - prescaler reset bit resets prescaler, self-clears unless sync hold
// - nonzero output action field routes waveform to pin; direction set by sw
// - non-pwm actions: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm: 01 reserved except toggle a in mode 7, 10 clear match set bottom, 11 inverse
// - fast pwm, compare equals top: match ignored, bottom action still done
// - phase pwm: 10 clear on up match, set on down; 11 inverse
// - phase pwm, compare equals top: match ignored, action done at top
// - control a bits 3:2 read as zero
// - mode field selects counting sequence and top source
// - compare update: immediate non-pwm, at top phase, at bottom fast
// - overflow flag at max modes 0,2,3; bottom phase; top mode 7
// - in non-pwm modes, force bit is a strobe forcing a match on the waveform only
// - forced match sets no flag and never clears the counter
// - force bits always read as zero
// - clock select: stop, /1, /8, /64, /256, /1024, pin fall, pin rise
// - match flags set on match, cleared by vector ack or writing one
// - counter write blocks the compare match on the next timer clock
module tmc0_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic [tmc0_pkg::TMC0_AW-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic external_count_pin,
  input wire logic ack_match_a,
  input wire logic ack_match_b,
  input wire logic ack_overflow,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_en_a,
  output logic wave_en_b,
  output logic match_flag_a,
  output logic match_flag_b,
  output logic overflow_flag,
  output logic [7:0] count_value,
  output logic timer_count_enable
);
  import tmc0_pkg::*;

  tmc0_state_t s_reg;
  tmc0_state_t s_next;

  always_comb begin
    logic tick;
    logic new_level;
    logic pin_edge;
    logic [7:0] top;
    logic is_fast;
    logic is_pc;
    logic non_pwm;
    logic at_top;
    logic hit;
    logic force_hit;
    logic cmp_top;
    logic wr_sync;
    logic [1:0] ack;
    logic [1:0] clr;
    logic ovf_set;
    tick = 1'b0;
    new_level = s_reg.pin_level;
    pin_edge = 1'b0;
    top = TMC0_MAX;
    is_fast = 1'b0;
    is_pc = 1'b0;
    non_pwm = 1'b0;
    at_top = 1'b0;
    hit = 1'b0;
    force_hit = 1'b0;
    cmp_top = 1'b0;
    wr_sync = wr_en && (addr == TMC0_ADDR_SYNC);
    ack = {ack_match_b, ack_match_a};
    clr = 2'b00;
    ovf_set = 1'b0;
    s_next = s_reg;

    // pin passes three flops; a level counts once the last two agree
    s_next.pin_sync = {s_reg.pin_sync[1:0], external_count_pin};
    if (s_reg.pin_sync[2] == s_reg.pin_sync[1]) begin
      new_level = s_reg.pin_sync[2];
    end
    s_next.pin_level = new_level;

    s_next.presc = s_reg.prescaler_reset_bit ? 10'h000 :
      s_reg.presc + 10'h001;

    case (s_reg.clock_select_field)
      TMC0_CS_STOP: tick = 1'b0;
      TMC0_CS_DIV1: tick = 1'b1;
      TMC0_CS_DIV8: tick = (s_reg.presc & TMC0_TAP8) == TMC0_TAP8;
      TMC0_CS_DIV64: tick = (s_reg.presc & TMC0_TAP64) == TMC0_TAP64;
      TMC0_CS_DIV256: tick = (s_reg.presc & TMC0_TAP256) == TMC0_TAP256;
      TMC0_CS_DIV1024: tick = (s_reg.presc & TMC0_TAP1024) == TMC0_TAP1024;
      TMC0_CS_EXT_FALL: pin_edge = s_reg.pin_level & ~new_level;
      TMC0_CS_EXT_RISE: pin_edge = ~s_reg.pin_level & new_level;
      default: tick = 1'b0;
    endcase
    // a held prescaler reset halts every source, pin edges included
    tick = (tick | pin_edge) & ~s_reg.prescaler_reset_bit;
    s_next.tick_q = tick;

    case (s_reg.wave_mode)
      TMC0_M_PC_FF: is_pc = 1'b1;
      TMC0_M_FAST_FF: is_fast = 1'b1;
      TMC0_M_CTC: top = s_reg.cmp_active[0];
      TMC0_M_PC_A: begin
        is_pc = 1'b1;
        top = s_reg.cmp_active[0];
      end
      TMC0_M_FAST_A: begin
        is_fast = 1'b1;
        top = s_reg.cmp_active[0];
      end
      default: top = TMC0_MAX;
    endcase
    non_pwm = ~is_fast & ~is_pc;
    at_top = s_reg.count_value == top;

    if (tick) begin
      s_next.block_match = 1'b0;
      if (is_pc) begin
        case (s_reg.dir)
          TMC0_UP: begin
            if (at_top) begin
              s_next.dir = TMC0_DOWN;
              s_next.count_value = s_reg.count_value - 8'h01;
              s_next.cmp_active = s_reg.cmp_buffer;
            end else begin
              s_next.count_value = s_reg.count_value + 8'h01;
            end
          end
          TMC0_DOWN: begin
            if (s_reg.count_value == TMC0_BOTTOM) begin
              s_next.dir = TMC0_UP;
              s_next.count_value = s_reg.count_value + 8'h01;
              s_next.overflow_flag = 1'b1;
              ovf_set = 1'b1;
            end else begin
              s_next.count_value = s_reg.count_value - 8'h01;
            end
          end
          default: s_next.dir = TMC0_UP;
        endcase
      end else begin
        s_next.dir = TMC0_UP;
        s_next.count_value = at_top ? TMC0_BOTTOM :
          s_reg.count_value + 8'h01;
        if (s_reg.wave_mode == TMC0_M_FAST_A ? at_top :
            s_reg.count_value == TMC0_MAX) begin
          s_next.overflow_flag = 1'b1;
          ovf_set = 1'b1;
        end
        if (is_fast && at_top) begin
          s_next.cmp_active = s_reg.cmp_buffer;
        end
      end
    end

    for (int i = 0; i < 2; i++) begin
      hit = tick && !s_reg.block_match &&
        (s_reg.count_value == s_reg.cmp_active[i]);
      force_hit = wr_en && (addr == TMC0_ADDR_CTRL_B) && non_pwm &&
        wr_data[TMC0_FORCE_A_BIT - i];
      cmp_top = s_reg.cmp_active[i] == top;
      if (non_pwm && (hit || force_hit)) begin
        case (s_reg.out_action[i])
          2'b01: s_next.wave_out[i] = ~s_reg.wave_out[i];
          2'b10: s_next.wave_out[i] = 1'b0;
          2'b11: s_next.wave_out[i] = 1'b1;
          default: s_next.wave_out[i] = s_reg.wave_out[i];
        endcase
      end else if (is_fast && tick) begin
        if (s_reg.out_action[i][1]) begin
          if (hit && !cmp_top) begin
            s_next.wave_out[i] = s_reg.out_action[i][0];
          end
          if (at_top) begin
            s_next.wave_out[i] = ~s_reg.out_action[i][0];
          end
        end else if (s_reg.out_action[i][0] && i == 0 &&
            s_reg.wave_mode[2] && hit) begin
          // toggle exists for channel a only with compare a as top
          s_next.wave_out[i] = ~s_reg.wave_out[i];
        end
      end else if (is_pc && tick) begin
        if (s_reg.out_action[i][1]) begin
          if (cmp_top) begin
            if (at_top && s_reg.dir == TMC0_UP) begin
              s_next.wave_out[i] = ~s_reg.out_action[i][0];
            end
          end else if (hit) begin
            s_next.wave_out[i] = (s_reg.dir == TMC0_UP) ?
              s_reg.out_action[i][0] : ~s_reg.out_action[i][0];
          end
        end else if (s_reg.out_action[i][0] && i == 0 &&
            s_reg.wave_mode[2] && hit) begin
          s_next.wave_out[i] = ~s_reg.wave_out[i];
        end
      end
      // forced matches never reach the flags or the counter clear
      if (wr_en && addr == TMC0_ADDR_FLAGS) begin
        clr[i] = wr_data[TMC0_FLAG_A_BIT - i];
      end
      // set wins over a clear in the same cycle
      s_next.match_flag[i] = (s_reg.match_flag[i] & ~clr[i] & ~ack[i]) |
        hit;
    end

    if (wr_sync) begin
      s_next.sync_hold_mode = wr_data[TMC0_SYNC_HOLD_BIT];
      s_next.prescaler_reset_bit = wr_data[TMC0_PRESC_RST_BIT];
    end else if (!s_reg.sync_hold_mode) begin
      s_next.prescaler_reset_bit = 1'b0;
    end

    if (wr_en) begin
      case (addr)
        TMC0_ADDR_CTRL_A: begin
          s_next.out_action[0] = wr_data[7:6];
          s_next.out_action[1] = wr_data[5:4];
          s_next.wave_mode[1:0] = wr_data[1:0];
        end
        TMC0_ADDR_CTRL_B: begin
          s_next.wave_mode[2] = wr_data[TMC0_MODE_HI_BIT];
          s_next.clock_select_field = wr_data[2:0];
        end
        TMC0_ADDR_CMP_A, TMC0_ADDR_CMP_B: begin
          // pwm modes stage the value; non-pwm modes load at once
          s_next.cmp_buffer[addr[0] ? 0 : 1] = wr_data;
          if (non_pwm) begin
            s_next.cmp_active[addr[0] ? 0 : 1] = wr_data;
          end
        end
        TMC0_ADDR_COUNT: begin
          s_next.count_value = wr_data;
          s_next.block_match = 1'b1;
        end
        TMC0_ADDR_FLAGS: begin
          if (wr_data[TMC0_FLAG_OVF_BIT]) begin
            s_next.overflow_flag = 1'b0;
          end
        end
        default: s_next.block_match = s_next.block_match;
      endcase
    end
    if (ack_overflow) begin
      s_next.overflow_flag = 1'b0;
    end
    // overflow event outranks a same-cycle clear
    if (ovf_set) begin
      s_next.overflow_flag = 1'b1;
    end

    s_next.wave_en[0] = |s_next.out_action[0];
    s_next.wave_en[1] = |s_next.out_action[1];

    s_next.rd_data = TMC0_REG_RESET;
    if (rd_en) begin
      case (addr)
        TMC0_ADDR_CTRL_A: s_next.rd_data = {s_reg.out_action[0],
          s_reg.out_action[1], 2'b00, s_reg.wave_mode[1:0]};
        TMC0_ADDR_CTRL_B: s_next.rd_data = {4'h0, s_reg.wave_mode[2],
          s_reg.clock_select_field};
        TMC0_ADDR_SYNC: s_next.rd_data = {s_reg.sync_hold_mode, 6'h00,
          s_reg.prescaler_reset_bit};
        TMC0_ADDR_CMP_A: s_next.rd_data = s_reg.cmp_buffer[0];
        TMC0_ADDR_CMP_B: s_next.rd_data = s_reg.cmp_buffer[1];
        TMC0_ADDR_COUNT: s_next.rd_data = s_reg.count_value;
        TMC0_ADDR_FLAGS: s_next.rd_data = {3'h0, s_reg.match_flag[0],
          s_reg.match_flag[1], 1'b0, s_reg.overflow_flag, 1'b0};
        default: s_next.rd_data = TMC0_REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= TMC0_STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd_data;
  assign wave_out_a = s_reg.wave_out[0];
  assign wave_out_b = s_reg.wave_out[1];
  assign wave_en_a = s_reg.wave_en[0];
  assign wave_en_b = s_reg.wave_en[1];
  assign match_flag_a = s_reg.match_flag[0];
  assign match_flag_b = s_reg.match_flag[1];
  assign overflow_flag = s_reg.overflow_flag;
  assign count_value = s_reg.count_value;
  assign timer_count_enable = s_reg.tick_q;

endmodule : tmc0_timer
